// >>> logic/lmcc_core.sv
/*
 legacy mode and context control: mode bits, ram block swap, pointer
 guards, repeat eligibility, conditional subtract and context save/restore.
 assumes the stack memory takes one word per accepted stack beat and returns
 read data in the same cycle as the beat.
*/
// How it works
// - interrupt pushes seven 32-bit words in fixed order; return pops them back.
// - after reset both small ram blocks map identically in program and data.
// - swap map bit zero exchanges the blocks in program space only.
// - only the legacy map select instruction clears the swap map bit.
// - any reset restores the uniform native block mapping.
// - reset selects legacy object mode with legacy decode and timing.
// - legacy mode blocks writes to upper bits of extended pointers.
// - reset clears every extended pointer.
// - native object enter sets object mode; native decode follows.
// - native mode lets upper pointer bits be written, carries included.
// - repeat applies only to the eligible class; others run once.
// - conditional subtract uses a 34-bit difference, loads diff+1 or acc shifted.
// - carry takes the unsigned compare; zero and negative follow the result.
// - conditional subtract leaves overflow flag and counter alone.
// - mode or map instructions flush the pipeline.
// - swap map bit is bit 11, resets to one, survives restores.
// - object mode bit 9 saves and restores with status word one.
`default_nettype none
`include "lmcc_defs.svh"
module lmcc_core
   import lmcc_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   input  wire lmcc_pkg::lmcc_op_t   op_in,
   input  wire logic [15:0]          operand_in,
   input  wire logic [15:0]          st1_wr_in,
   input  wire lmcc_pkg::lmcc_ptr_wr_t ptr_wr_in,
   input  wire logic                 rpt_pending_in,
   input  wire lmcc_pkg::lmcc_class_t cls_in,
   input  wire logic                 int_req_in,
   input  wire logic                 iret_req_in,
   input  wire lmcc_pkg::lmcc_ctx_t  ctx_in,
   input  wire logic [31:0]          stack_rdata_in,
   input  wire logic                 ram_space_prog_in,
   input  wire logic                 ram_sel_in,
   output logic                      ram_phys_sel_out,
   output logic                      native_decode_out,
   output logic                      flush_out,
   output logic                      repeat_ok_out,
   output logic [31:0]               sum_out,
   output logic [15:0]               st0_out,
   output logic [15:0]               st1_out,
   output logic [255:0]              xptr_out,
   output lmcc_pkg::lmcc_stack_t     stack_out,
   output logic                      ctx_busy_out,
   output logic                      ctx_done_out,
   output lmcc_pkg::lmcc_ctx_t       ctx_out
);
   typedef enum logic [1:0] {LMCC_IDLE, LMCC_PUSH, LMCC_POP} lmcc_ctx_state_t;

   logic [15:0]     st0_r, st1_r;
   logic [31:0]     sum_r;
   logic            ram_phys_r, flush_r, repeat_r, done_r, busy_r;
   lmcc_ctx_state_t state_r;
   logic [2:0]      beat_r;
   lmcc_stack_t     stack_r;
   lmcc_ctx_t       ctx_r;
   logic [31:0]     xp_val [8];

   wire obj_w = st1_r[`LMCC_ST1_OBJ_BIT];
   wire map_w = st1_r[`LMCC_ST1_MAP_BIT];

   // conditional subtract datapath
   wire [32:0] acc_sh_w  = {sum_r, 1'b0};
   wire [32:0] opd_sh_w  = {1'b0, operand_in, 16'h0000};
   wire [33:0] diff_w    = {1'b0, acc_sh_w} - {1'b0, opd_sh_w};
   wire        ge_w      = (acc_sh_w >= opd_sh_w);
   wire [31:0] sub_res_w = ge_w ? diff_w[31:0] + 32'h0000_0001 : acc_sh_w[31:0];
   wire        is_sub_w  = (op_in == LMCC_OP_SUBCS) && state_r == LMCC_IDLE;

   // only C, Z, N move; overflow bit and counter field are kept as they were
   wire [15:0] st0_sub_w = {st0_r[15:6], sub_res_w[31], (sub_res_w == 32'h0000_0000), ge_w,
                            st0_r[2:0]};

   // status word one next values; map bit never follows written or popped data
   wire [15:0] st1_wr_keep_w = {st1_wr_in[15:12], map_w, st1_wr_in[10:0]};
   wire [15:0] st1_pop_w     = {stack_rdata_in[15:12], map_w, stack_rdata_in[10:0]};
   wire        mode_op_w     = (op_in == LMCC_OP_OBJ_ENTER) || (op_in == LMCC_OP_OBJ_LEAVE) ||
                               (op_in == LMCC_OP_MAP_NATIVE) || (op_in == LMCC_OP_MAP_LEGACY);

   // context beats: word i of the push order
   logic [31:0] push_word_w;
   always_comb
   begin
      push_word_w = 32'h0000_0000;
      unique case (beat_r)
         3'h0: push_word_w = {ctx_in.t, st0_r};
         3'h1: push_word_w = ctx_in.acc;
         3'h2: push_word_w = ctx_in.prod;
         3'h3: push_word_w = {ctx_in.ptr1, ctx_in.ptr0};
         3'h4: push_word_w = {ctx_in.dp, st1_r};
         3'h5: push_word_w = {ctx_in.dbg, ctx_in.interrupt_enable_word};
         3'h6: push_word_w = ctx_in.pc;
         default: push_word_w = 32'h0000_0000;
      endcase
   end
   // pops run in reverse so the last word pushed is the first restored
   // a read beat is registered, so its data is taken one edge later when beat_r has moved on
   wire       pop_beat_w = stack_r.valid && stack_r.rd_not_wr;
   wire [2:0] pop_idx_w  = `LMCC_CTX_LAST + 3'h1 - beat_r;

   // repeat eligibility is the same in both object modes
   wire elig_w = (cls_in != LMCC_CL_OTHER);

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         st0_r      <= `LMCC_ST0_RESET;
         st1_r      <= `LMCC_ST1_RESET;
         sum_r      <= 32'h0000_0000;
         ram_phys_r <= `LMCC_RAM_SEL_A;
         flush_r    <= 1'b0;
         repeat_r   <= 1'b0;
         done_r     <= 1'b0;
         state_r    <= LMCC_IDLE;
         busy_r     <= 1'b0;
         beat_r     <= 3'h0;
         stack_r    <= '0;
         ctx_r      <= '0;
      end
      else if (ce_in)
      begin
         // swap only when program space is addressed and legacy map is active
         ram_phys_r <= (ram_space_prog_in && !map_w) ? ~ram_sel_in : ram_sel_in;
         flush_r    <= mode_op_w && state_r == LMCC_IDLE;
         repeat_r   <= rpt_pending_in && elig_w;
         done_r     <= 1'b0;
         stack_r    <= '0;
         if (is_sub_w)
         begin
            sum_r <= sub_res_w;
            st0_r <= st0_sub_w;
         end
         unique case (state_r)
            LMCC_IDLE:
            begin
               if (int_req_in)
               begin
                  state_r <= LMCC_PUSH;
                  busy_r  <= 1'b1;
                  beat_r  <= 3'h0;
               end
               else if (iret_req_in)
               begin
                  state_r <= LMCC_POP;
                  busy_r  <= 1'b1;
                  beat_r  <= 3'h0;
               end
               unique case (op_in)
                  LMCC_OP_OBJ_ENTER:  st1_r[`LMCC_ST1_OBJ_BIT] <= 1'b1;
                  LMCC_OP_OBJ_LEAVE:  st1_r[`LMCC_ST1_OBJ_BIT] <= 1'b0;
                  LMCC_OP_MAP_NATIVE: st1_r[`LMCC_ST1_MAP_BIT] <= 1'b1;
                  LMCC_OP_MAP_LEGACY: st1_r[`LMCC_ST1_MAP_BIT] <= 1'b0;
                  LMCC_OP_ST1_WRITE:  st1_r <= st1_wr_keep_w;
                  default: ;
               endcase
            end
            LMCC_PUSH:
            begin
               stack_r <= '{valid: 1'b1, rd_not_wr: 1'b0, data: push_word_w};
               beat_r  <= beat_r + 3'h1;
               if (beat_r == `LMCC_CTX_LAST)
               begin
                  state_r <= LMCC_IDLE;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
               end
            end
            LMCC_POP:
            begin
               stack_r <= '{valid: 1'b1, rd_not_wr: 1'b1, data: 32'h0000_0000};
               beat_r  <= beat_r + 3'h1;
               if (beat_r == `LMCC_CTX_LAST)
               begin
                  state_r <= LMCC_IDLE;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
               end
            end
            default:
            begin
               state_r <= LMCC_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
         // read data stands while the read beat is out, so the last word lands one edge after done
         if (pop_beat_w)
         begin
            unique case (pop_idx_w)
               3'h0:
               begin
                  ctx_r.t <= stack_rdata_in[31:16];
                  st0_r   <= stack_rdata_in[15:0];
               end
               3'h1: ctx_r.acc <= stack_rdata_in;
               3'h2: ctx_r.prod <= stack_rdata_in;
               3'h3: {ctx_r.ptr1, ctx_r.ptr0} <= stack_rdata_in;
               3'h4:
               begin
                  ctx_r.dp <= stack_rdata_in[31:16];
                  st1_r    <= st1_pop_w;
               end
               3'h5: {ctx_r.dbg, ctx_r.interrupt_enable_word} <= stack_rdata_in;
               3'h6: ctx_r.pc <= stack_rdata_in;
               default: ;
            endcase
         end
      end
   end

   // a pointer write lands only in the register picked by its index; eight guarded cells, one per register
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_xp
         lmcc_xptr #(
            .LOW_MASK ((gi < 6) ? `LMCC_XP_LOW_MASK_A : `LMCC_XP_LOW_MASK_B)
         ) u_xp (
            .clk_sys_in (clk_sys_in),
            .rst_n_in   (rst_n_in),
            .ce_in      (ce_in),
            .wr_in      (ptr_wr_in.valid && ptr_wr_in.idx == 3'(gi)),
            .native_in  (obj_w),
            .data_in    (ptr_wr_in.data),
            .value_out  (xp_val[gi])
         );
         assign xptr_out[gi*32 +: 32] = xp_val[gi];
      end
   endgenerate

   assign ram_phys_sel_out  = ram_phys_r;
   assign native_decode_out = obj_w;
   assign flush_out         = flush_r;
   assign repeat_ok_out     = repeat_r;
   assign sum_out           = sum_r;
   assign st0_out           = st0_r;
   assign st1_out           = st1_r;
   assign stack_out         = stack_r;
   assign ctx_busy_out      = busy_r;
   assign ctx_done_out      = done_r;
   assign ctx_out           = ctx_r;

   chk_map_clear_src : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ($fell(st1_r[`LMCC_ST1_MAP_BIT])) |-> $past(op_in == LMCC_OP_MAP_LEGACY && ce_in))
      else $error("swap map bit cleared without legacy map select");
   chk_reset_mode : assert property (@(posedge clk_sys_in)
      (!rst_n_in) |=> (st1_r[`LMCC_ST1_OBJ_BIT] == 1'b0 && st1_r[`LMCC_ST1_MAP_BIT] == 1'b1))
      else $error("reset did not restore legacy mode and native map");
   chk_ptr_reset : assert property (@(posedge clk_sys_in)
      (!rst_n_in) |=> (xptr_out == 256'h0))
      else $error("reset did not clear the extended pointers");
   chk_data_noswap : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && !ram_space_prog_in) |=> (ram_phys_sel_out == $past(ram_sel_in)))
      else $error("data space access was swapped");
   chk_obj_enter : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && state_r == LMCC_IDLE && op_in == LMCC_OP_OBJ_ENTER) |=> native_decode_out)
      else $error("object enter did not select native decode");
   chk_flush_mode : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && state_r == LMCC_IDLE && mode_op_w) |=> flush_out)
      else $error("mode instruction did not flush");
   chk_pop_map_keep : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (state_r == LMCC_POP) |=> $stable(st1_r[`LMCC_ST1_MAP_BIT]))
      else $error("restore changed the swap map bit");
   chk_sub_ovf_keep : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && is_sub_w) |=> (st0_r[15:6] == $past(st0_r[15:6])))
      else $error("conditional subtract touched overflow state");
   chk_sub_result : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && is_sub_w && ge_w) |=> (sum_r == $past(diff_w[31:0]) + 32'h0000_0001 && st0_r[3]))
      else $error("conditional subtract result wrong");
   // a stalled clock enable stretches the push, hence the wide upper bound
   chk_push_len : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (state_r == LMCC_IDLE && ce_in && int_req_in) |-> ##[8:300] done_r)
      else $error("context push did not finish");
   chk_repeat_other : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && cls_in == LMCC_CL_OTHER) |=> !repeat_ok_out)
      else $error("repeat granted to ineligible instruction");
endmodule : lmcc_core
`default_nettype wire

// >>> common/lmcc_defs.svh
/*
 file holds the offsets, field positions, reset values and counts of the
 legacy mode and context block as macros.
 assumes it is included by the package and by the design files.
*/
`ifndef LMCC_DEFS_SVH
`define LMCC_DEFS_SVH
`define LMCC_ST1_OBJ_BIT       9
`define LMCC_ST1_MAP_BIT       11
`define LMCC_ST1_RESET         16'h0803
`define LMCC_ST0_RESET         16'h0000
`define LMCC_XP_ZERO           32'h0000_0000
`define LMCC_XP_LOW_MASK_A     32'h0000_FFFF
`define LMCC_XP_LOW_MASK_B     32'h003F_FFFF
`define LMCC_CTX_WORDS         4'h7
`define LMCC_CTX_LAST          3'h6
`define LMCC_ST0_C_BIT         3
`define LMCC_ST0_Z_BIT         4
`define LMCC_ST0_N_BIT         5
`define LMCC_RAM_SEL_A         1'h0
`define LMCC_RAM_SEL_B         1'h1
`define LMCC_CLK_PERIOD_NS     100
`endif

// >>> common/lmcc_pkg.sv
/*
 package holds the types of the legacy mode and context block.
 assumes lmcc_defs.svh is on the include path.
*/
`default_nettype none
`include "lmcc_defs.svh"
package lmcc_pkg;
   typedef enum logic [2:0] {
      LMCC_OP_NONE,
      LMCC_OP_OBJ_ENTER,
      LMCC_OP_OBJ_LEAVE,
      LMCC_OP_MAP_NATIVE,
      LMCC_OP_MAP_LEGACY,
      LMCC_OP_SUBCS,
      LMCC_OP_ST1_WRITE
   } lmcc_op_t;

   typedef enum logic [3:0] {
      LMCC_CL_ROTATE,
      LMCC_CL_NORMALIZE,
      LMCC_CL_COND_SUB,
      LMCC_CL_MAC,
      LMCC_CL_LISTED_MOVE,
      LMCC_CL_ADD_SUB,
      LMCC_CL_SHIFT,
      LMCC_CL_PROD_MOVE,
      LMCC_CL_OTHER
   } lmcc_class_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  idx;
      logic [31:0] data;
      logic        via_arith;
   } lmcc_ptr_wr_t;

   typedef struct packed {
      logic        valid;
      logic        rd_not_wr;
      logic [31:0] data;
   } lmcc_stack_t;

   typedef struct packed {
      logic [15:0] t;
      logic [15:0] st0;
      logic [31:0] acc;
      logic [31:0] prod;
      logic [15:0] ptr1;
      logic [15:0] ptr0;
      logic [15:0] dp;
      logic [15:0] st1;
      logic [15:0] dbg;
      logic [15:0] interrupt_enable_word;
      logic [31:0] pc;
   } lmcc_ctx_t;
endpackage : lmcc_pkg
`default_nettype wire

// >>> logic/lmcc_xptr.sv
/*
 one extended pointer register with its upper-bit write guard.
 qualifies writes with its own clock enable input; writes arrive unqualified.
*/
`default_nettype none
`include "lmcc_defs.svh"
module lmcc_xptr #(
   parameter logic [31:0] LOW_MASK = `LMCC_XP_LOW_MASK_A
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic        wr_in,
   input  wire logic        native_in,
   input  wire logic [31:0] data_in,
   output logic      [31:0] value_out
);
   logic [31:0] value_r;
   logic [31:0] value_nxt;
   wire  [31:0] keep_mask = native_in ? 32'h0000_0000 : ~LOW_MASK;

   // in legacy mode upper bits hold; nonzero leftovers stay until software clears them
   assign value_nxt = (value_r & keep_mask) | (data_in & ~keep_mask);

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         value_r <= `LMCC_XP_ZERO;
      else if (ce_in && wr_in)
         value_r <= value_nxt;
   end

   assign value_out = value_r;

   chk_upper_guard : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (ce_in && wr_in && !native_in) |=> ((value_r & ~LOW_MASK) == $past(value_r & ~LOW_MASK)))
      else $error("upper pointer bits changed in legacy mode");
endmodule : lmcc_xptr
`default_nettype wire

// >>> test/lmcc_stack_mem.sv
/*
 stack memory model on the far side of the context save/restore port.
 assumes one beat per cycle and read data wanted in the cycle of the read beat.
*/
`default_nettype none
module lmcc_stack_mem
   import lmcc_pkg::*;
(
   input  wire logic                  clk_sys_in,
   input  wire lmcc_pkg::lmcc_stack_t stack_in,
   output logic [31:0]                rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem_r [0:15];
   logic [3:0]  sp_r   = 4'h0;
   logic [31:0] last_r = 32'h0;
   wire  logic  pop_w;
   assign pop_w = stack_in.valid & stack_in.rd_not_wr;
   // off a read beat the bus shows the inverse of the last word, so stale data never matches
   assign rdata_out = pop_w ? mem_r[sp_r - 4'h1] : ~last_r;
   always @(posedge clk_sys_in)
   begin
      if (stack_in.valid && !stack_in.rd_not_wr)
      begin
         mem_r[sp_r] <= stack_in.data;
         sp_r        <= sp_r + 4'h1;
         last_r      <= stack_in.data;
      end
      else if (pop_w)
      begin
         sp_r   <= sp_r - 4'h1;
         last_r <= mem_r[sp_r - 4'h1];
      end
   end
endmodule : lmcc_stack_mem
`default_nettype wire

// >>> test/lmcc_core_test.sv
/*
 self-checking bench of the legacy mode and context block.
 assumes lmcc_pkg compiled first and the stack model beside it.
*/
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] t=%0t act=%h exp=%h", $time, (a), (e)); end end
module lmcc_core_test;
   import lmcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk_sys_in, rst_n_in, ce_in, rpt_pending_in, int_req_in, iret_req_in;
   logic          ram_space_prog_in, ram_sel_in;
   lmcc_op_t      op_in;
   lmcc_class_t   cls_in;
   logic [15:0]   operand_in, st1_wr_in, st0_out, st1_out;
   lmcc_ptr_wr_t  ptr_wr_in;
   lmcc_ctx_t     ctx_in, ctx_out;
   lmcc_stack_t   stack_out;
   wire logic [31:0] stack_rdata_in;
   logic          ram_phys_sel_out, native_decode_out, flush_out, repeat_ok_out, ctx_busy_out, ctx_done_out;
   logic [31:0]   sum_out;
   logic [255:0]  xptr_out;
   int            n_mismatch = 0;
   int            compares   = 0;

   lmcc_core dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .op_in(op_in),
      .operand_in(operand_in), .st1_wr_in(st1_wr_in), .ptr_wr_in(ptr_wr_in), .rpt_pending_in(rpt_pending_in),
      .cls_in(cls_in), .int_req_in(int_req_in), .iret_req_in(iret_req_in), .ctx_in(ctx_in),
      .stack_rdata_in(stack_rdata_in), .ram_space_prog_in(ram_space_prog_in), .ram_sel_in(ram_sel_in),
      .ram_phys_sel_out(ram_phys_sel_out), .native_decode_out(native_decode_out), .flush_out(flush_out),
      .repeat_ok_out(repeat_ok_out), .sum_out(sum_out), .st0_out(st0_out), .st1_out(st1_out),
      .xptr_out(xptr_out), .stack_out(stack_out), .ctx_busy_out(ctx_busy_out),
      .ctx_done_out(ctx_done_out), .ctx_out(ctx_out));
   lmcc_stack_mem mem_u (.clk_sys_in(clk_sys_in), .stack_in(stack_out), .rdata_out(stack_rdata_in));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   task print_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task do_reset;
      @(posedge clk_sys_in) rst_n_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(negedge clk_sys_in);
   endtask : do_reset

   task do_op(input lmcc_op_t op, input logic [15:0] opd);
      @(posedge clk_sys_in);
      op_in      <= op;
      operand_in <= opd;
      @(posedge clk_sys_in) op_in <= LMCC_OP_NONE;
      @(negedge clk_sys_in);
   endtask : do_op

   task chk_map(input logic prog, input logic sel, input logic exp);
      @(posedge clk_sys_in);
      ram_space_prog_in <= prog;
      ram_sel_in        <= sel;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      `CHK(ram_phys_sel_out, exp)
   endtask : chk_map

   task wr_ptr(input logic [2:0] idx, input logic [31:0] d, input logic [31:0] exp);
      @(posedge clk_sys_in) ptr_wr_in <= '{1'b1, idx, d, 1'b0};
      @(posedge clk_sys_in) ptr_wr_in.valid <= 1'b0;
      @(negedge clk_sys_in);
      `CHK(xptr_out[32*idx +: 32], exp)
   endtask : wr_ptr

   // counts beats of one push or pop and checks the done pulse at the seventh beat
   task beats(input logic rd, input logic [31:0] exp [7]);
      int n;
      n = 0;
      for (int k = 0; k < 12; k++)
      begin
         @(negedge clk_sys_in);
         if (stack_out.valid === 1'b1)
         begin
            `CHK(stack_out.rd_not_wr, rd)
            if (!rd)
               `CHK(stack_out.data, exp[n])
            n++;
            if (n == 7)
               `CHK(ctx_done_out, 1'b1)
         end
      end
      `CHK(n, 7)
   endtask : beats

   task t_reset_vals;
      `CHK(st1_out, 16'h0803)
      `CHK(native_decode_out, 1'b0)
      `CHK(xptr_out, 256'h0)
      `CHK({sum_out, st0_out, ctx_busy_out}, 49'h0)
   endtask : t_reset_vals

   task t_subcs;
      logic [31:0] acc;
      logic [32:0] d;
      logic        ge;
      logic [15:0] opd [6];
      opd = '{16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'hFFFF};
      acc = 32'h0;
      for (int i = 0; i < 6; i++)
      begin
         do_op(LMCC_OP_SUBCS, opd[i]);
         ge  = ({1'b0, acc, 1'b0} >= {2'b00, opd[i], 16'h0000});
         d   = {acc, 1'b0} - {1'b0, opd[i], 16'h0000};
         acc = ge ? d[31:0] + 32'h1 : {acc[30:0], 1'b0};
         `CHK(sum_out, acc)
         `CHK(st0_out, {10'h0, acc[31], acc == 32'h0, ge, 3'h0})
      end
   endtask : t_subcs

   task t_repeat;
      for (int c = 0; c < 9; c++)
      begin
         @(posedge clk_sys_in);
         rpt_pending_in <= 1'b1;
         cls_in         <= lmcc_class_t'(c[3:0]);
         @(posedge clk_sys_in) rpt_pending_in <= 1'b0;
         @(negedge clk_sys_in);
         `CHK(repeat_ok_out, c != 8)
      end
      // an eligible class without a pending repeat runs once
      @(posedge clk_sys_in) cls_in <= LMCC_CL_ROTATE;
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      `CHK(repeat_ok_out, 1'b0)
   endtask : t_repeat

   task t_ram_map;
      chk_map(1'b1, 1'b0, 1'b0);
      chk_map(1'b0, 1'b1, 1'b1);
      @(posedge clk_sys_in) st1_wr_in <= 16'h0003;
      do_op(LMCC_OP_ST1_WRITE, 16'h0);
      `CHK(st1_out, 16'h0803)
      do_op(LMCC_OP_MAP_LEGACY, 16'h0);
      `CHK({flush_out, st1_out}, 17'h10003)
      chk_map(1'b1, 1'b0, 1'b1);
      chk_map(1'b1, 1'b1, 1'b0);
      chk_map(1'b0, 1'b0, 1'b0);
      @(posedge clk_sys_in) st1_wr_in <= 16'h0803;
      do_op(LMCC_OP_ST1_WRITE, 16'h0);
      `CHK(st1_out, 16'h0003)
      do_op(LMCC_OP_MAP_NATIVE, 16'h0);
      `CHK({flush_out, st1_out}, 17'h10803)
      do_op(LMCC_OP_MAP_LEGACY, 16'h0);
      `CHK(st1_out, 16'h0003)
      do_reset();
      `CHK(st1_out, 16'h0803)
      chk_map(1'b1, 1'b0, 1'b0);
   endtask : t_ram_map

   task t_ptr_obj;
      wr_ptr(3'h0, 32'hFFFF_FFFF, 32'h0000_FFFF);
      wr_ptr(3'h6, 32'hFFFF_FFFF, 32'h003F_FFFF);
      do_op(LMCC_OP_OBJ_ENTER, 16'h0);
      `CHK({flush_out, native_decode_out}, 2'h3)
      wr_ptr(3'h5, 32'h1234_5678, 32'h1234_5678);
      wr_ptr(3'h7, 32'hFFC0_0001, 32'hFFC0_0001);
      // with the clock enable low the write must leave the pointer as it was
      @(posedge clk_sys_in) ce_in <= 1'b0;
      wr_ptr(3'h7, 32'h0000_0005, 32'hFFC0_0001);
      @(posedge clk_sys_in) ce_in <= 1'b1;
   endtask : t_ptr_obj

   task t_context;
      logic [31:0] exp [7];
      exp = '{{ctx_in.t, 16'h0000}, ctx_in.acc, ctx_in.prod, {ctx_in.ptr1, ctx_in.ptr0},
              {ctx_in.dp, 16'h0A03}, {ctx_in.dbg, ctx_in.interrupt_enable_word}, ctx_in.pc};
      @(posedge clk_sys_in) int_req_in <= 1'b1;
      @(posedge clk_sys_in) int_req_in <= 1'b0;
      beats(1'b0, exp);
      do_op(LMCC_OP_MAP_LEGACY, 16'h0);
      wr_ptr(3'h5, 32'h0, 32'h0);
      wr_ptr(3'h7, 32'h0, 32'h0);
      do_op(LMCC_OP_OBJ_LEAVE, 16'h0);
      `CHK(native_decode_out, 1'b0)
      @(posedge clk_sys_in) iret_req_in <= 1'b1;
      @(posedge clk_sys_in) iret_req_in <= 1'b0;
      beats(1'b1, exp);
      `CHK({ctx_out.t, ctx_out.acc, ctx_out.prod, ctx_out.ptr1, ctx_out.ptr0, ctx_out.dp, ctx_out.dbg,
            ctx_out.interrupt_enable_word, ctx_out.pc}, {ctx_in.t, ctx_in.acc, ctx_in.prod, ctx_in.ptr1, ctx_in.ptr0,
            ctx_in.dp, ctx_in.dbg, ctx_in.interrupt_enable_word, ctx_in.pc})
      `CHK(st1_out, 16'h0203)
   endtask : t_context

   initial
   begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      op_in = LMCC_OP_NONE;
      operand_in = 16'h0;
      st1_wr_in = 16'h0;
      ptr_wr_in = '0;
      rpt_pending_in = 1'b0;
      cls_in = LMCC_CL_OTHER;
      int_req_in = 1'b0;
      iret_req_in = 1'b0;
      ram_space_prog_in = 1'b0;
      ram_sel_in = 1'b0;
      ctx_in = '{16'h1111, 16'h0, 32'hA5A5_0102, 32'h5A5A_0304, 16'h2222, 16'h3333, 16'h0044, 16'h0,
                 16'h5555, 16'h6666, 32'h003F_0123};
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(negedge clk_sys_in);
      t_reset_vals();
      t_subcs();
      t_repeat();
      t_ram_map();
      t_ptr_obj();
      t_context();
      print_verdict();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      n_mismatch++;
      print_verdict();
   end
endmodule : lmcc_core_test
`default_nettype wire
